// File: rtl/burst_bus_unit.sv
`timescale 1ns/1ps
module burst_bus_unit #(
  parameter int SELFTEST_CYCLES = bus_unit_pkg::SELFTEST_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Request port.
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_rmw,
  input wire logic [bus_unit_pkg::ADDR_W-1:0] req_addr,
  input wire logic [bus_unit_pkg::LEN_W-1:0] req_len,
  input wire logic [1:0] req_be_n,
  output logic req_ready_ff,
  input wire logic [bus_unit_pkg::DATA_W-1:0] wr_data,
  output logic wr_take_ff,
  output logic [bus_unit_pkg::DATA_W-1:0] rd_data_ff,
  output logic rd_valid_ff,
  // Status.
  output logic init_done_ff,
  output logic init_fail_ff,
  output logic float_mode_ff,
  output logic [bus_unit_pkg::IRQ_N-1:0] irq_edge_ff,
  // Address and data pins.
  output logic [15:0] upper_address_lines_ff,
  output logic upper_address_oe_ff,
  input wire logic [bus_unit_pkg::DATA_W-1:0] shared_addr_data_in,
  output logic [bus_unit_pkg::DATA_W-1:0] shared_addr_data_out_ff,
  output logic shared_addr_data_oe_ff,
  output logic [bus_unit_pkg::WORD_W-1:0] burst_word_address_lines_ff,
  // Strobes and control pins; one enable covers this group.
  output logic ctrl_oe_ff,
  output logic addr_latch_ff,
  output logic address_status_strobe_n_ff,
  output logic write_not_read_ff,
  output logic data_transfer_strobe_n_ff,
  output logic transfer_direction_ff,
  output logic [1:0] byte_lane_enables_n_ff,
  output logic burst_final_marker_n_ff,
  // Handshake pins.
  input wire logic ready_n,
  input wire logic hold_req,
  output logic bus_grant_out_ff,
  output logic bus_grant_oe_ff,
  input wire logic lock_n_in,
  output logic lock_n_out_ff,
  output logic lock_n_oe_ff,
  // Interrupt pins.
  input wire logic direct_irq_zero_n,
  input wire logic direct_irq_one_n,
  input wire logic direct_irq_two_or_request_n,
  input wire logic direct_irq_three_or_acknowledge_n
);
  localparam int ST_W = $clog2(SELFTEST_CYCLES + 1);
  localparam logic [ST_W-1:0] ST_LAST = ST_W'(SELFTEST_CYCLES - 1);
  localparam logic [ST_W-1:0] ST_ZERO = '0;

  pin_sync_if pins ();
  bus_unit_pkg::bus_state_e state_ff, nxt_state;
  bus_unit_pkg::strap_mode_e mode;
  logic phase_ff;
  logic tick;
  logic [3:0] strap_ff;
  logic [ST_W-1:0] test_cnt_ff;
  logic init_busy_ff;
  logic burst_idx_ff;
  logic half_ff;
  logic [bus_unit_pkg::DATA_W-1:0] lo_ff;
  logic [31:0] sum_ff;
  logic [31:0] word_sum;
  logic [bus_unit_pkg::ADDR_W-1:0] addr_ff;
  logic write_ff, rmw_ff;
  logic [bus_unit_pkg::LEN_W-1:0] left_ff;
  logic [1:0] be_ff;
  logic [bus_unit_pkg::WORD_W-1:0] word_ff;
  logic [bus_unit_pkg::DATA_W-1:0] wdata_ff;
  logic lock_hold_ff;
  logic [bus_unit_pkg::IRQ_N-1:0] irq_prev_ff;
  logic take, step, last, ready_ok, lock_busy, hold_s, fail_now;
  logic recover_ff;

  assign pins.raw = {shared_addr_data_in, ready_n, hold_req, lock_n_in, direct_irq_three_or_acknowledge_n,
                     direct_irq_two_or_request_n, direct_irq_one_n, direct_irq_zero_n};

  pin_sync u_sync (
    .sys_clk(sys_clk),
    .pins(pins)
  );

  assign hold_s = pins.sync[bus_unit_pkg::SYNC_HOLD];
  assign ready_ok = !pins.sync[bus_unit_pkg::SYNC_READY];
  assign lock_busy = !pins.sync[bus_unit_pkg::SYNC_LOCK] && !lock_hold_ff;
  assign tick = phase_ff;
  assign last = (left_ff == bus_unit_pkg::LEN_ONE);
  assign step = tick && (state_ff == bus_unit_pkg::ST_DATA) && ready_ok && !recover_ff;
  assign take = tick && (state_ff == bus_unit_pkg::ST_IDLE) && !hold_s && !init_busy_ff && init_done_ff && req_valid;
  assign word_sum = sum_ff + {pins.sync[bus_unit_pkg::SYNC_AD_LSB +: bus_unit_pkg::DATA_W], lo_ff};
  assign fail_now = step && last && init_busy_ff && burst_idx_ff && (word_sum != 32'h0000_0000);

  // The processor cycle is two input clocks; the phase bit marks its second half.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= !phase_ff;
    end
  end

  // After a data step the synchronised ready and data still belong to the old halfword, so one tick is skipped.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      recover_ff <= 1'b0;
    end else if (step) begin
      recover_ff <= 1'b1;
    end else if (tick) begin
      recover_ff <= 1'b0;
    end
  end

  // Straps are followed while reset is held, so the last value before release counts.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strap_ff <= {pins.sync[bus_unit_pkg::SYNC_LOCK], pins.sync[bus_unit_pkg::SYNC_IRQ_LSB + 3],
                   pins.sync[bus_unit_pkg::SYNC_IRQ_LSB + 1], pins.sync[bus_unit_pkg::SYNC_IRQ_LSB]};
    end
  end

  // Strap decode; a reserved setting runs the self-test.
  always_comb begin
    if (!strap_ff[bus_unit_pkg::STRAP_LOCK]) begin
      mode = bus_unit_pkg::MODE_FLOAT;
    end else if (!strap_ff[bus_unit_pkg::STRAP_IRQ3]) begin
      mode = bus_unit_pkg::MODE_RESERVED;
    end else if (strap_ff[bus_unit_pkg::STRAP_IRQ0]) begin
      mode = bus_unit_pkg::MODE_SELFTEST;
    end else if (!strap_ff[bus_unit_pkg::STRAP_IRQ1]) begin
      mode = bus_unit_pkg::MODE_SKIP;
    end else begin
      mode = bus_unit_pkg::MODE_RESERVED;
    end
  end

  // Bus sequencer; it moves only at the end of a processor cycle.
  always_comb begin
    nxt_state = state_ff;
    if (tick) begin
      unique case (state_ff)
        bus_unit_pkg::ST_BOOT: begin
          if (mode == bus_unit_pkg::MODE_FLOAT) begin
            nxt_state = bus_unit_pkg::ST_FLOAT;
          end else if (mode == bus_unit_pkg::MODE_SKIP) begin
            nxt_state = bus_unit_pkg::ST_IDLE;
          end else begin
            nxt_state = bus_unit_pkg::ST_SELFTEST;
          end
        end
        bus_unit_pkg::ST_SELFTEST: begin
          if (test_cnt_ff == ST_LAST) begin
            nxt_state = bus_unit_pkg::ST_IDLE;
          end
        end
        bus_unit_pkg::ST_IDLE: begin
          if (hold_s) begin
            nxt_state = bus_unit_pkg::ST_HOLD;
          end else if (init_busy_ff) begin
            nxt_state = bus_unit_pkg::ST_ADDR;
          end else if (take && req_rmw && !req_write && lock_busy) begin
            nxt_state = bus_unit_pkg::ST_LOCKWAIT;
          end else if (take) begin
            nxt_state = bus_unit_pkg::ST_ADDR;
          end
        end
        bus_unit_pkg::ST_LOCKWAIT: begin
          if (!lock_busy) begin
            nxt_state = bus_unit_pkg::ST_ADDR;
          end
        end
        bus_unit_pkg::ST_ADDR: nxt_state = bus_unit_pkg::ST_DATA;
        bus_unit_pkg::ST_DATA: begin
          if (fail_now) begin
            nxt_state = bus_unit_pkg::ST_FAIL;
          end else if (step && last) begin
            nxt_state = bus_unit_pkg::ST_IDLE;
          end
        end
        bus_unit_pkg::ST_HOLD: begin
          if (!hold_s) begin
            nxt_state = bus_unit_pkg::ST_IDLE;
          end
        end
        bus_unit_pkg::ST_FAIL: nxt_state = bus_unit_pkg::ST_FAIL;
        bus_unit_pkg::ST_FLOAT: nxt_state = bus_unit_pkg::ST_FLOAT;
      endcase
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_ff <= bus_unit_pkg::ST_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Self-test cycle counter, in processor cycles.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      test_cnt_ff <= ST_ZERO;
    end else if (tick && state_ff == bus_unit_pkg::ST_SELFTEST) begin
      test_cnt_ff <= test_cnt_ff + 1'b1;
    end
  end

  // Transfer context: captured on a request or an init burst, stepped per data cycle.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      addr_ff <= '0;
      write_ff <= 1'b0;
      rmw_ff <= 1'b0;
      left_ff <= bus_unit_pkg::LEN_ONE;
      be_ff <= bus_unit_pkg::BE_NONE;
      word_ff <= '0;
      wdata_ff <= '0;
    end else if (tick && state_ff == bus_unit_pkg::ST_IDLE && !hold_s && init_busy_ff) begin
      addr_ff <= burst_idx_ff ? bus_unit_pkg::INIT_STEP : bus_unit_pkg::INIT_BASE;
      write_ff <= 1'b0;
      rmw_ff <= 1'b0;
      left_ff <= bus_unit_pkg::LEN_W'(bus_unit_pkg::BURST_MAX);
      be_ff <= bus_unit_pkg::INIT_BE;
      word_ff <= '0;
    end else if (take) begin
      addr_ff <= req_addr;
      write_ff <= req_write;
      rmw_ff <= req_rmw;
      left_ff <= req_len;
      be_ff <= req_be_n;
      word_ff <= req_addr[bus_unit_pkg::WORD_LSB +: bus_unit_pkg::WORD_W];
      wdata_ff <= wr_data;
    end else if (step && !last) begin
      left_ff <= left_ff - 1'b1;
      word_ff <= word_ff + 1'b1;
      wdata_ff <= wr_data;
    end
  end

  // Initialization: checksum over the first words of memory after self-test, or straight after boot when the straps skip it.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      init_busy_ff <= 1'b0;
      init_done_ff <= 1'b0;
      burst_idx_ff <= 1'b0;
      half_ff <= 1'b0;
      lo_ff <= '0;
      sum_ff <= 32'h0000_0000;
    end else begin
      if (tick && state_ff != bus_unit_pkg::ST_IDLE && nxt_state == bus_unit_pkg::ST_IDLE && !init_done_ff
          && !init_busy_ff) begin
        init_busy_ff <= 1'b1;
      end
      if (step && init_busy_ff) begin
        half_ff <= !half_ff;
        if (!half_ff) begin
          lo_ff <= pins.sync[bus_unit_pkg::SYNC_AD_LSB +: bus_unit_pkg::DATA_W];
        end else begin
          sum_ff <= word_sum;
        end
        if (last) begin
          burst_idx_ff <= 1'b1;
          if (burst_idx_ff) begin
            init_busy_ff <= 1'b0;
            init_done_ff <= !fail_now;
          end
        end
      end
    end
  end

  // Lock ownership: taken in the read address state, dropped in the write address state.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lock_hold_ff <= 1'b0;
    end else if (tick && state_ff == bus_unit_pkg::ST_ADDR && rmw_ff) begin
      lock_hold_ff <= !write_ff;
    end
  end

  // Direct interrupt pins: a high-then-low pair of processor-cycle samples marks a request.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_prev_ff <= '1;
      irq_edge_ff <= '0;
    end else begin
      irq_edge_ff <= '0;
      if (tick) begin
        irq_prev_ff <= pins.sync[bus_unit_pkg::SYNC_IRQ_LSB +: bus_unit_pkg::IRQ_N];
        irq_edge_ff <= irq_prev_ff & ~pins.sync[bus_unit_pkg::SYNC_IRQ_LSB +: bus_unit_pkg::IRQ_N];
      end
    end
  end

  // User side handshake and read data.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      req_ready_ff <= 1'b0;
      wr_take_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
      init_fail_ff <= 1'b0;
      float_mode_ff <= 1'b0;
    end else begin
      req_ready_ff <= (nxt_state == bus_unit_pkg::ST_IDLE) && init_done_ff && !take;
      wr_take_ff <= (take && req_write) || (step && !last && write_ff);
      rd_valid_ff <= step && !write_ff && !init_busy_ff;
      if (step && !write_ff) begin
        rd_data_ff <= pins.sync[bus_unit_pkg::SYNC_AD_LSB +: bus_unit_pkg::DATA_W];
      end
      init_fail_ff <= (state_ff == bus_unit_pkg::ST_FAIL);
      float_mode_ff <= (state_ff == bus_unit_pkg::ST_FLOAT);
    end
  end

  // Bus pins follow the state one input clock later, all by the same amount.
  always_ff @(posedge sys_clk) begin
    if (!nrst || state_ff == bus_unit_pkg::ST_BOOT) begin
      upper_address_oe_ff <= 1'b0;
      shared_addr_data_oe_ff <= 1'b0;
      ctrl_oe_ff <= 1'b1;
      addr_latch_ff <= 1'b0;
      address_status_strobe_n_ff <= 1'b1;
      data_transfer_strobe_n_ff <= 1'b1;
      transfer_direction_ff <= 1'b1;
      write_not_read_ff <= 1'b0;
      byte_lane_enables_n_ff <= bus_unit_pkg::BE_NONE;
      burst_final_marker_n_ff <= 1'b1;
      bus_grant_out_ff <= 1'b0;
      bus_grant_oe_ff <= 1'b1;
      lock_n_oe_ff <= 1'b0;
      upper_address_lines_ff <= '0;
      shared_addr_data_out_ff <= '0;
      burst_word_address_lines_ff <= '0;
      lock_n_out_ff <= 1'b0;
    end else if (state_ff == bus_unit_pkg::ST_FLOAT) begin
      upper_address_oe_ff <= 1'b0;
      shared_addr_data_oe_ff <= 1'b0;
      ctrl_oe_ff <= 1'b0;
      bus_grant_oe_ff <= 1'b0;
      lock_n_oe_ff <= 1'b0;
    end else begin
      upper_address_oe_ff <= (state_ff != bus_unit_pkg::ST_HOLD);
      ctrl_oe_ff <= (state_ff != bus_unit_pkg::ST_HOLD);
      bus_grant_out_ff <= (state_ff == bus_unit_pkg::ST_HOLD);
      bus_grant_oe_ff <= 1'b1;
      upper_address_lines_ff <= addr_ff[bus_unit_pkg::UPPER_LSB +: 16];
      addr_latch_ff <= (state_ff == bus_unit_pkg::ST_ADDR) && !phase_ff;
      address_status_strobe_n_ff <= (state_ff != bus_unit_pkg::ST_ADDR);
      data_transfer_strobe_n_ff <= (state_ff != bus_unit_pkg::ST_DATA);
      shared_addr_data_oe_ff <= (state_ff == bus_unit_pkg::ST_ADDR)
                                || (state_ff == bus_unit_pkg::ST_DATA && write_ff);
      if (state_ff == bus_unit_pkg::ST_ADDR) begin
        shared_addr_data_out_ff <= addr_ff[bus_unit_pkg::DATA_W-1:0];
        burst_word_address_lines_ff <= addr_ff[bus_unit_pkg::WORD_LSB +: bus_unit_pkg::WORD_W];
        write_not_read_ff <= write_ff;
        transfer_direction_ff <= write_ff;
      end else if (state_ff == bus_unit_pkg::ST_DATA) begin
        shared_addr_data_out_ff <= wdata_ff;
        burst_word_address_lines_ff <= word_ff;
      end
      if (state_ff == bus_unit_pkg::ST_DATA) begin
        byte_lane_enables_n_ff <= be_ff;
        burst_final_marker_n_ff <= !last;
      end else if (state_ff == bus_unit_pkg::ST_SELFTEST || state_ff == bus_unit_pkg::ST_FAIL) begin
        byte_lane_enables_n_ff <= bus_unit_pkg::BE_NONE;
        burst_final_marker_n_ff <= 1'b0;
      end else begin
        byte_lane_enables_n_ff <= bus_unit_pkg::BE_NONE;
        burst_final_marker_n_ff <= 1'b1;
      end
      lock_n_out_ff <= 1'b0;
      lock_n_oe_ff <= (state_ff == bus_unit_pkg::ST_ADDR && rmw_ff) ? !write_ff : lock_hold_ff;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  AST_DIVIDE: assert property ($past(nrst) |-> phase_ff != $past(phase_ff)) else $error("phase did not toggle");
  AST_STROBES_EXCL: assert property (!(address_status_strobe_n_ff == 1'b0 && data_transfer_strobe_n_ff == 1'b0))
    else $error("address and data strobes both low");
  AST_ALE_EARLY: assert property ($rose(addr_latch_ff) |=> !addr_latch_ff && !address_status_strobe_n_ff ##1
    !data_transfer_strobe_n_ff) else $error("latch strobe not confined to address state");
  AST_DIR_STABLE: assert property (!data_transfer_strobe_n_ff && $past(!data_transfer_strobe_n_ff)
    |-> transfer_direction_ff == $past(transfer_direction_ff)) else $error("direction moved under data strobe");
  AST_UPPER_HOLD: assert property (!data_transfer_strobe_n_ff && $past(!data_transfer_strobe_n_ff)
    |-> upper_address_lines_ff == $past(upper_address_lines_ff)) else $error("upper address moved in burst");
  AST_WAIT: assert property (tick && state_ff == bus_unit_pkg::ST_DATA && !ready_ok
    |=> state_ff == bus_unit_pkg::ST_DATA && left_ff == $past(left_ff)) else $error("wait state not inserted");
  AST_WORD_STEP: assert property (step && !last |=> ##1 burst_word_address_lines_ff == $past(word_ff, 2) + 3'h1)
    else $error("word address did not step");
  AST_HOLD_FLOAT: assert property (bus_grant_out_ff |-> !shared_addr_data_oe_ff && !ctrl_oe_ff
    && !upper_address_oe_ff) else $error("bus driven while granted");
  AST_FLOAT_MODE: assert property (float_mode_ff |-> !ctrl_oe_ff && !bus_grant_oe_ff && !lock_n_oe_ff
    && !shared_addr_data_oe_ff) else $error("output driven in float mode");
  AST_FAIL_SHOW: assert property (state_ff == bus_unit_pkg::ST_SELFTEST |=> !burst_final_marker_n_ff
    && byte_lane_enables_n_ff == bus_unit_pkg::BE_NONE) else $error("failure pattern missing in self-test");
  AST_LOCK_TAKE: assert property (tick && state_ff == bus_unit_pkg::ST_ADDR && rmw_ff && !write_ff
    |-> ##[0:1] lock_n_oe_ff) else $error("lock not asserted in read address state");
  AST_READ_FLOAT: assert property (!data_transfer_strobe_n_ff && !write_not_read_ff |-> !shared_addr_data_oe_ff)
    else $error("shared lines driven during read data");

  COV_BURST_READ: cover property (step && last && !write_ff && !init_busy_ff);
  COV_WAIT: cover property (tick && state_ff == bus_unit_pkg::ST_DATA && !ready_ok);
  COV_HOLD: cover property ($rose(bus_grant_out_ff));
  COV_RMW: cover property ($rose(lock_n_oe_ff) ##[1:200] $fell(lock_n_oe_ff));
endmodule : burst_bus_unit

// File: rtl/bus_unit_pkg.sv
package bus_unit_pkg;
  // Bus geometry.
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam int UPPER_LSB = 16;
  localparam int WORD_LSB = 1;
  localparam int WORD_W = 3;
  localparam int LEN_W = 4;
  localparam logic [LEN_W-1:0] LEN_ONE = 4'h1;
  localparam int BURST_MAX = 8;
  // Byte lane codes, active low.
  localparam logic [1:0] BE_NONE = 2'h3;
  // Initialization figures.
  localparam int SELFTEST_CYCLES_DEF = 47000;
  localparam int INIT_WORDS = 8;
  localparam int INIT_BURSTS = 2;
  localparam logic [ADDR_W-1:0] INIT_BASE = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] INIT_STEP = 32'h0000_0010;
  localparam logic [1:0] INIT_BE = 2'h0;
  // Minimum reset width asked of the reset driver, in input clock cycles.
  localparam int RESET_MIN_CYCLES = 41;
  // Layout of the synchronised input vector.
  localparam int IRQ_N = 4;
  localparam int SYNC_IRQ_LSB = 0;
  localparam int SYNC_LOCK = 4;
  localparam int SYNC_HOLD = 5;
  localparam int SYNC_READY = 6;
  localparam int SYNC_AD_LSB = 7;
  localparam int SYNC_W = 23;
  // Strap bit positions within the captured strap word.
  localparam int STRAP_IRQ0 = 0;
  localparam int STRAP_IRQ1 = 1;
  localparam int STRAP_IRQ3 = 2;
  localparam int STRAP_LOCK = 3;

  typedef enum logic [1:0] {MODE_SELFTEST, MODE_SKIP, MODE_RESERVED, MODE_FLOAT} strap_mode_e;
  typedef enum logic [3:0] {
    ST_BOOT, ST_SELFTEST, ST_IDLE, ST_LOCKWAIT, ST_ADDR, ST_DATA, ST_HOLD, ST_FAIL, ST_FLOAT
  } bus_state_e;
endpackage : bus_unit_pkg

// File: rtl/pin_sync_if.sv
`timescale 1ns/1ps
interface pin_sync_if;
  // Raw pin levels and their synchronised copies.
  logic [bus_unit_pkg::SYNC_W-1:0] raw;
  logic [bus_unit_pkg::SYNC_W-1:0] sync;
  modport syncer (input raw, output sync);
  modport core (output raw, input sync);
endinterface : pin_sync_if

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  // Clock.
  input wire logic sys_clk,
  // Pins in, synchronised levels out.
  pin_sync_if.syncer pins
);
  logic [bus_unit_pkg::SYNC_W-1:0] meta_ff;
  logic [bus_unit_pkg::SYNC_W-1:0] stable_ff;

  // Two flip-flops per pin; no reset so the straps can be seen while reset is held.
  for (genvar i = 0; i < bus_unit_pkg::SYNC_W; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      meta_ff[i] <= pins.raw[i];
      stable_ff[i] <= meta_ff[i];
    end
  end

  assign pins.sync = stable_ff;
endmodule : pin_sync

// File: testbench/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  // Clock.
  input wire logic sys_clk,
  // Bus pins from the unit, and the slow switch from the test.
  input wire logic addr_latch,
  input wire logic [15:0] ad_out,
  input wire logic [2:0] word,
  input wire logic den_n,
  input wire logic dir,
  input wire logic slow,
  // Answer pins.
  output logic ready_n,
  output logic [15:0] ad_in
);
  logic [15:0] mem [0:31];
  logic [1:0] base;
  logic [1:0] cnt;
  // Boot image whose eight words sum to zero.
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    {mem[3], mem[2], mem[1], mem[0]} = 64'hEDCB_A988_1234_5678;
    ready_n = 1'b1;
    ad_in = 16'h0000;
    base = 2'h0;
    cnt = 2'h0;
  end
  // Answers change just after the edge; idle lines toggle so stale data never looks valid.
  always @(posedge sys_clk) begin
    #1;
    if (addr_latch) base = ad_out[5:4];
    cnt = cnt + 2'h1;
    ready_n = den_n | (slow & cnt[1]);
    if (!den_n && dir) mem[{base, word}] = ad_out;
    ad_in = (!den_n && !dir) ? mem[{base, word}] : ~ad_in;
  end
endmodule : mem_model

// File: testbench/tb_burst_bus_interface_and_init.sv
`timescale 1ns/1ps
module tb_burst_bus_interface_and_init;
  // Stimulus, pins and bookkeeping.
  logic sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_rmw = 1'b0, hold_req = 1'b0;
  logic slow = 1'b0, lock_drv_n = 1'b1, lock_seen = 1'b0;
  logic [31:0] req_addr = 32'h0, a_r;
  logic [3:0] req_len = 4'h1, irq_n = 4'hF, edge_seen = 4'h0, irq_edge;
  logic [1:0] req_be_n = 2'h0, be_n;
  logic [15:0] wr_data = 16'h0, rd_data, ad_out, ad_in;
  logic req_ready, wr_take, rd_valid, init_done, init_fail, float_mode, ua_oe, ad_oe, ctrl_oe, ale, as_n;
  logic den_n, dir, burst_final_marker_n, grant, lock_oe, ready_n;
  logic [2:0] word;
  logic [15:0] shadow [0:31];
  logic [15:0] exp_q[$], wq[$];
  int seed = 30, miscompares = 0, cmp_count = 0, cycles = 0, k;
  wire lock_n = lock_drv_n & ~lock_oe;

  burst_bus_unit #(.SELFTEST_CYCLES(4)) dut (.sys_clk, .nrst, .req_valid, .req_write, .req_rmw, .req_addr,
    .req_len, .req_be_n, .req_ready_ff(req_ready), .wr_data, .wr_take_ff(wr_take), .rd_data_ff(rd_data),
    .rd_valid_ff(rd_valid), .init_done_ff(init_done), .init_fail_ff(init_fail), .float_mode_ff(float_mode),
    .irq_edge_ff(irq_edge), .upper_address_lines_ff(), .upper_address_oe_ff(ua_oe), .shared_addr_data_in(ad_in),
    .shared_addr_data_out_ff(ad_out), .shared_addr_data_oe_ff(ad_oe), .burst_word_address_lines_ff(word),
    .ctrl_oe_ff(ctrl_oe), .addr_latch_ff(ale), .address_status_strobe_n_ff(as_n), .write_not_read_ff(),
    .data_transfer_strobe_n_ff(den_n), .transfer_direction_ff(dir), .byte_lane_enables_n_ff(be_n),
    .burst_final_marker_n_ff(burst_final_marker_n), .ready_n, .hold_req, .bus_grant_out_ff(grant), .bus_grant_oe_ff(),
    .lock_n_in(lock_n), .lock_n_out_ff(), .lock_n_oe_ff(lock_oe), .direct_irq_zero_n(irq_n[0]),
    .direct_irq_one_n(irq_n[1]), .direct_irq_two_or_request_n(irq_n[2]),
    .direct_irq_three_or_acknowledge_n(irq_n[3]));
  mem_model partner (.sys_clk, .addr_latch(ale), .ad_out, .word, .den_n, .dir, .slow, .ready_n, .ad_in);

  always #5 sys_clk = ~sys_clk;

  task check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task test_done;
    $display("cmp_count=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // Waits a bounded time for the ready level, then checks that it arrived.
  task wait_ready(input logic lvl);
    for (k = 0; k < 3000 && req_ready !== lvl; k++) @(posedge sys_clk);
    #1;
    check({15'h0, req_ready}, {15'h0, lvl});
  endtask : wait_ready

  // Issues one burst; notes write data for the feeder and read expectations for the monitor.
  task xfer(input logic w, input logic read_modify_write, input logic [31:0] a, input logic [3:0] n);
    logic [4:0] ix;
    wait_ready(1'b1);
    wq.delete();
    for (int i = 0; i < n; i++) begin
      ix = {a[5:4], a[3:1] + i[2:0]};
      if (w) shadow[ix] = 16'($random(seed));
      if (w) wq.push_back(shadow[ix]);
      else exp_q.push_back(shadow[ix]);
    end
    if (w) wr_data = wq[0];
    req_valid = 1'b1;
    req_write = w;
    req_rmw = read_modify_write;
    req_addr = a;
    req_len = n;
    req_be_n = w ? 2'h0 : 2'($random(seed));
    wait_ready(1'b0);
    req_valid = 1'b0;
  endtask : xfer

  // Cycle ceiling, sticky flags and next write halfword after each take.
  always @(posedge sys_clk) begin
    #1;
    cycles++;
    lock_seen = lock_seen | lock_oe;
    edge_seen = edge_seen | irq_edge;
    if (wr_take === 1'b1 && wq.size() > 1) begin
      void'(wq.pop_front());
      wr_data = wq[0];
    end
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  // Compares each returned halfword with the oldest expectation.
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1 && exp_q.size() == 0) check(rd_data, 16'hxxxx);
    else if (rd_valid === 1'b1) check(rd_data, exp_q.pop_front());
  end

  // Main sequence.
  initial begin
    foreach (shadow[i]) shadow[i] = 16'h0000;
    {shadow[3], shadow[2], shadow[1], shadow[0]} = 64'hEDCB_A988_1234_5678;
    repeat (15) @(posedge sys_clk);
    #1;
    check({11'h0, dir, as_n, den_n, grant, ad_oe}, 16'h001C);
    @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    check({13'h0, burst_final_marker_n, be_n}, 16'h0003);
    wait_ready(1'b1);
    check({14'h0, init_done, init_fail}, 16'h0002);
    xfer(1'b0, 1'b0, 32'h0, 4'h8);
    for (int n = 1; n <= 8; n++) begin
      slow = n[0];
      a_r = {16'($random(seed)), 10'h0, 2'h2, 3'($random(seed)), 1'b0};
      xfer(1'b1, 1'b0, a_r, 4'(n));
      xfer(1'b0, 1'b0, a_r, 4'(n));
    end
    lock_seen = 1'b0;
    xfer(1'b0, 1'b1, a_r, 4'h1);
    xfer(1'b1, 1'b1, a_r, 4'h2);
    wait_ready(1'b1);
    check({14'h0, lock_seen, lock_oe}, 16'h0002);
    hold_req = 1'b1;
    for (k = 0; k < 100 && grant !== 1'b1; k++) @(posedge sys_clk);
    #1;
    check({12'h0, grant, ua_oe, ad_oe, ctrl_oe}, 16'h0008);
    edge_seen = 4'h0;
    irq_n = 4'hD;
    repeat (6) @(posedge sys_clk);
    #1;
    irq_n = 4'hF;
    repeat (8) @(posedge sys_clk);
    #1;
    hold_req = 1'b0;
    wait_ready(1'b1);
    check({12'h0, edge_seen}, 16'h0002);
    check(16'(exp_q.size()), 16'h0000);
    nrst = 1'b0;
    lock_drv_n = 1'b0;
    repeat (bus_unit_pkg::RESET_MIN_CYCLES) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    lock_drv_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    check({12'h0, float_mode, ctrl_oe, ad_oe, req_ready}, 16'h0008);
    test_done();
  end
endmodule : tb_burst_bus_interface_and_init
